// file: design/ipa_arbiter.sv
// Priority evaluation of a processor interface: priority fields, mask
// threshold, binary point grouping, running priority and acknowledge.
// Assumes the distributor drives PENDING levels and clears pending on
// ACK_PULSE; register port strobes are one cycle and never overlap.
`timescale 1ns/100ps

module ipa_arbiter #(
	parameter int                  N_IRQ       = 16,
	parameter int                  IMPL_BITS   = 4,
	parameter logic [2:0]          MIN_BP      = 3'h0,
	parameter bit                  HAS_GROUPS  = 1'b1,
	parameter logic [N_IRQ-1:0]    FIXED_MASK  = '0,
	parameter logic [7:0]          FIXED_VALUE = 8'h00
) (
	input  wire logic               CLK,
	input  wire logic               RESET,
	input  wire logic [11:0]        ADDR,
	input  wire logic [31:0]        WDATA,
	input  wire logic               WR,
	input  wire logic               RD,
	output logic      [31:0]        RDATA,
	input  wire logic [N_IRQ-1:0]   PENDING,
	output logic                    IRQ_REQ,
	output logic                    ACK_PULSE,
	output logic      [9:0]         ACK_ID
);

	localparam logic [7:0] IMPL_MASK =
		8'(ipa_pkg::ALL_ONES_PRIO << (ipa_pkg::PRIO_W - IMPL_BITS));
	localparam logic [7:0] PRIO_MAX = IMPL_MASK;
	localparam logic [11:0] PRIO_END =
		12'(ipa_pkg::OFS_PRIO_BASE + 4 * N_IRQ);

	////////////////////////////////////////////////////////////////////////
	// Register state

	logic                   ctl_enable;
	logic                   ctl_cbps;
	logic [7:0]             mask_thr;
	logic [2:0]             bp_primary;
	logic [2:0]             bp_alias;
	logic [N_IRQ-1:0]       grp_sel;
	logic [N_IRQ-1:0]       active;
	logic [N_IRQ-1:0]       live;
	logic [7:0]             run_store [N_IRQ];
	logic [7:0]             prio      [N_IRQ];
	logic [N_IRQ-1:0]       prio_wr;

	logic                   wr_ctl;
	logic                   wr_mask;
	logic                   wr_bp;
	logic                   wr_abp;
	logic                   wr_drop;
	logic                   wr_deact;
	logic                   wr_grp;
	logic                   rd_ack;
	logic                   in_prio;
	logic [11:0]            prio_off;
	logic [9:0]             prio_idx;

	////////////////////////////////////////////////////////////////////////
	// Address decode

	always_comb begin
		wr_ctl   = 1'b0;
		wr_mask  = 1'b0;
		wr_bp    = 1'b0;
		wr_abp   = 1'b0;
		wr_drop  = 1'b0;
		wr_deact = 1'b0;
		wr_grp   = 1'b0;
		if (ADDR == ipa_pkg::OFS_CONTROL) begin
			wr_ctl = WR;
		end else if (ADDR == ipa_pkg::OFS_MASK) begin
			wr_mask = WR;
		end else if (ADDR == ipa_pkg::OFS_BP) begin
			wr_bp = WR;
		end else if (ADDR == ipa_pkg::OFS_ABP) begin
			wr_abp = WR;
		end else if (ADDR == ipa_pkg::OFS_DROP) begin
			wr_drop = WR;
		end else if (ADDR == ipa_pkg::OFS_DEACT) begin
			wr_deact = WR;
		end else if (ADDR == ipa_pkg::OFS_GROUP) begin
			wr_grp = WR;
		end
	end

	assign rd_ack   = RD && (ADDR == ipa_pkg::OFS_ACK);
	assign in_prio  = (ADDR >= ipa_pkg::OFS_PRIO_BASE) && (ADDR < PRIO_END)
		&& (ADDR[1:0] == ipa_pkg::WORD_ALIGN);
	assign prio_off = ADDR - ipa_pkg::OFS_PRIO_BASE;
	assign prio_idx = prio_off[11:2];

	////////////////////////////////////////////////////////////////////////
	// Per-interrupt priority fields

	genvar g;
	generate
		for (g = 0; g < N_IRQ; g++) begin : gen_prio
			assign prio_wr[g] = WR && in_prio && (prio_idx == 10'(g));
			ipa_prio_field #(
				.IMPL_BITS   (IMPL_BITS),
				.FIXED       (FIXED_MASK[g]),
				.FIXED_VALUE (FIXED_VALUE)
			) u_field (
				.clk   (CLK),
				.reset (RESET),
				.wr_en (prio_wr[g]),
				.wdata (WDATA[7:0]),
				.prio  (prio[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Interface configuration

	always_ff @(posedge CLK) begin
		if (RESET) begin
			ctl_enable <= 1'b0;
			ctl_cbps   <= 1'b0;
		end else if (wr_ctl) begin
			ctl_enable <= WDATA[ipa_pkg::CTL_ENABLE_BIT];
			ctl_cbps   <= WDATA[ipa_pkg::CTL_CBPS_BIT] & HAS_GROUPS;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			mask_thr <= ipa_pkg::MASK_RESET;
		end else if (wr_mask) begin
			mask_thr <= WDATA[7:0] & IMPL_MASK;
		end
	end

	// Values below the floor are raised to it rather than refused
	always_ff @(posedge CLK) begin
		if (RESET) begin
			bp_primary <= (ipa_pkg::BP_RESET > MIN_BP) ?
				ipa_pkg::BP_RESET : MIN_BP;
			bp_alias   <= (ipa_pkg::BP_RESET > MIN_BP) ?
				ipa_pkg::BP_RESET : MIN_BP;
		end else begin
			if (wr_bp) begin
				bp_primary <= (WDATA[2:0] < MIN_BP) ? MIN_BP : WDATA[2:0];
			end
			if (wr_abp && HAS_GROUPS) begin
				bp_alias <= (WDATA[2:0] < MIN_BP) ? MIN_BP : WDATA[2:0];
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			grp_sel <= '0;
		end else if (wr_grp && HAS_GROUPS) begin
			grp_sel <= WDATA[N_IRQ-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pending selection and running priority

	logic             found;
	logic [7:0]       best_prio;
	logic [9:0]       best_id;
	logic [7:0]       run_prio;
	logic [2:0]       bp_use;
	logic [7:0]       grp_mask;
	logic [7:0]       best_grp;
	logic             eligible;

	// Strict compare keeps the lowest id on a full-priority tie
	always_comb begin
		found     = 1'b0;
		best_prio = ipa_pkg::IDLE_PRIO;
		best_id   = ipa_pkg::SPURIOUS_ID;
		for (int i = 0; i < N_IRQ; i++) begin
			if (PENDING[i] && !active[i]
				&& (!found || prio[i] < best_prio)) begin
				found     = 1'b1;
				best_prio = prio[i];
				best_id   = 10'(i);
			end
		end
	end

	always_comb begin
		run_prio = ipa_pkg::IDLE_PRIO;
		for (int i = 0; i < N_IRQ; i++) begin
			if (live[i] && run_store[i] < run_prio) begin
				run_prio = run_store[i];
			end
		end
	end

	always_comb begin
		bp_use = bp_primary;
		if (HAS_GROUPS && grp_sel[best_id[3:0] % N_IRQ] && !ctl_cbps) begin
			bp_use = bp_alias;
		end
	end

	// Binary point 7 shifts every bit out, so all groups compare equal
	assign grp_mask = 8'(ipa_pkg::ALL_ONES_PRIO << ({1'b0, bp_use} + 4'h1));
	assign best_grp = best_prio & grp_mask;

	assign eligible = found && ctl_enable
		&& (best_prio < mask_thr)
		&& (best_prio != PRIO_MAX)
		&& (best_grp < run_prio);

	////////////////////////////////////////////////////////////////////////
	// Active and priority-drop tracking

	logic [9:0] wid;
	assign wid = WDATA[9:0];

	// Preemption takes effect only here, when the acknowledge is read
	always_ff @(posedge CLK) begin
		if (RESET) begin
			active <= '0;
			live   <= '0;
		end else begin
			for (int i = 0; i < N_IRQ; i++) begin
				if (rd_ack && eligible && best_id == 10'(i)) begin
					active[i] <= 1'b1;
					live[i]   <= 1'b1;
				end else begin
					if (wr_drop && wid == 10'(i)) begin
						live[i] <= 1'b0;
					end
					if (wr_deact && wid == 10'(i)) begin
						active[i] <= 1'b0;
						live[i]   <= 1'b0;
					end
				end
			end
		end
	end

	// Group priority is frozen at acknowledge so later writes cannot move it
	always_ff @(posedge CLK) begin
		if (RESET) begin
			for (int i = 0; i < N_IRQ; i++) begin
				run_store[i] <= ipa_pkg::IDLE_PRIO;
			end
		end else if (rd_ack && eligible) begin
			run_store[best_id[3:0] % N_IRQ] <= best_grp;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	always_ff @(posedge CLK) begin
		if (RESET) begin
			IRQ_REQ <= 1'b0;
		end else begin
			IRQ_REQ <= eligible;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			ACK_PULSE <= 1'b0;
			ACK_ID    <= ipa_pkg::SPURIOUS_ID;
		end else begin
			ACK_PULSE <= rd_ack && eligible;
			if (rd_ack) begin
				ACK_ID <= eligible ? best_id : ipa_pkg::SPURIOUS_ID;
			end
		end
	end

	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = '0;
		if (ADDR == ipa_pkg::OFS_CONTROL) begin
			rd_mux[ipa_pkg::CTL_ENABLE_BIT] = ctl_enable;
			rd_mux[ipa_pkg::CTL_CBPS_BIT]   = ctl_cbps;
		end else if (ADDR == ipa_pkg::OFS_MASK) begin
			rd_mux[7:0] = mask_thr;
		end else if (ADDR == ipa_pkg::OFS_BP) begin
			rd_mux[2:0] = bp_primary;
		end else if (ADDR == ipa_pkg::OFS_ABP) begin
			rd_mux[2:0] = bp_alias;
		end else if (ADDR == ipa_pkg::OFS_RUNNING) begin
			rd_mux[7:0] = run_prio;
		end else if (ADDR == ipa_pkg::OFS_ACK) begin
			rd_mux[9:0] = eligible ? best_id : ipa_pkg::SPURIOUS_ID;
		end else if (ADDR == ipa_pkg::OFS_PENDVIEW) begin
			rd_mux[9:0] = found ? best_id : ipa_pkg::SPURIOUS_ID;
		end else if (ADDR == ipa_pkg::OFS_ACTIVE) begin
			rd_mux[N_IRQ-1:0] = active;
		end else if (ADDR == ipa_pkg::OFS_GROUP) begin
			rd_mux[N_IRQ-1:0] = grp_sel;
		end else if (in_prio) begin
			rd_mux[7:0] = prio[prio_idx[3:0] % N_IRQ];
		end
	end

	// Unmapped addresses read as zero
	always_ff @(posedge CLK) begin
		if (RESET) begin
			RDATA <= '0;
		end else begin
			RDATA <= RD ? rd_mux : '0;
		end
	end

endmodule : ipa_arbiter

// file: design/ipa_pkg.sv
// Shared constants for the interrupt priority arbiter: register offsets,
// field positions, reset values and special identifiers.
// Assumes a word-aligned register port with 12-bit byte addresses.
package ipa_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int PRIO_W = 8;
	localparam int BP_W   = 3;
	localparam int ID_W   = 10;

	// Register byte offsets
	localparam logic [11:0] OFS_CONTROL   = 12'h000;
	localparam logic [11:0] OFS_MASK      = 12'h004;
	localparam logic [11:0] OFS_BP        = 12'h008;
	localparam logic [11:0] OFS_ABP       = 12'h00c;
	localparam logic [11:0] OFS_RUNNING   = 12'h010;
	localparam logic [11:0] OFS_ACK       = 12'h014;
	localparam logic [11:0] OFS_DROP      = 12'h018;
	localparam logic [11:0] OFS_DEACT     = 12'h01c;
	localparam logic [11:0] OFS_PENDVIEW  = 12'h020;
	localparam logic [11:0] OFS_ACTIVE    = 12'h024;
	localparam logic [11:0] OFS_GROUP     = 12'h028;
	localparam logic [11:0] OFS_PRIO_BASE = 12'h400;

	// Control register fields
	localparam int CTL_ENABLE_BIT = 0;
	localparam int CTL_CBPS_BIT   = 1;

	// Reset values
	localparam logic [7:0] MASK_RESET    = 8'h00;
	localparam logic [7:0] PRIO_RESET    = 8'h00;
	localparam logic [2:0] BP_RESET      = 3'h0;
	localparam logic [7:0] IDLE_PRIO     = 8'hff;
	localparam logic [7:0] ALL_ONES_PRIO = 8'hff;

	// Special identifiers
	localparam logic [9:0] SPURIOUS_ID = 10'h3ff;

	localparam logic [1:0] WORD_ALIGN = 2'h0;

endpackage : ipa_pkg

// file: design/ipa_prio_field.sv
// One per-interrupt priority field with unimplemented low bits.
// Assumes writes arrive as a one-cycle strobe with byte data.
`timescale 1ns/100ps

module ipa_prio_field #(
	parameter int         IMPL_BITS   = 4,
	parameter bit         FIXED       = 1'b0,
	parameter logic [7:0] FIXED_VALUE = 8'h00
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       wr_en,
	input  wire logic [7:0] wdata,
	output logic      [7:0] prio
);

	localparam logic [7:0] IMPL_MASK =
		8'(ipa_pkg::ALL_ONES_PRIO << (ipa_pkg::PRIO_W - IMPL_BITS));

	logic [7:0] stored;

	// Low bits never store, so they read as zero and ignore writes
	always_ff @(posedge clk) begin
		if (reset) begin
			stored <= ipa_pkg::PRIO_RESET;
		end else if (wr_en && !FIXED) begin
			stored <= wdata & IMPL_MASK;
		end
	end

	assign prio = FIXED ? (FIXED_VALUE & IMPL_MASK) : stored;

endmodule : ipa_prio_field

// file: tb/interrupt_priority_arbiter_tb.sv
// Self-checking bench of the interrupt priority arbiter.
// Assumes default parameters: 16 interrupts, four priority bits.
`timescale 1ns/100ps

module interrupt_priority_arbiter_tb;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        rd_d = 1'b0;
	logic [31:0] rdata;
	logic [31:0] rdata_x;
	logic        wr_x = 1'b0;
	logic        rd_x = 1'b0;
	logic        sel_x = 1'b0;
	logic        ack_d = 1'b0;
	logic [31:0] rd_exp;
	logic [15:0] pending;
	logic [15:0] raise = 16'h0;
	logic        irq_req;
	logic        ack_pulse;
	logic [9:0]  ack_id;
	logic [31:0] exp_q[$];
	logic [31:0] v;
	int          err_total = 0;
	int          samples_checked = 0;
	int          seed = 32'hdc41;

	always #2 clk = ~clk;

	ipa_arbiter ipa_arbiter_i (.CLK(clk), .RESET(reset), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PENDING(pending),
		.IRQ_REQ(irq_req), .ACK_PULSE(ack_pulse), .ACK_ID(ack_id));
	ipa_src_model ipa_src_model_i (.clk(clk), .reset(reset), .raise(raise),
		.ack_pulse(ack_pulse), .ack_id(ack_id), .pending(pending));
	// Second copy: fixed field, raised binary point floor, no grouping
	ipa_arbiter #(.FIXED_MASK(16'h0001), .FIXED_VALUE(8'h5a), .MIN_BP(3'h2),
		.HAS_GROUPS(1'b0)) ipa_arbiter_fix_i (.CLK(clk), .RESET(reset),
		.ADDR(addr), .WDATA(wdata), .WR(wr_x), .RD(rd_x), .RDATA(rdata_x),
		.PENDING(pending), .IRQ_REQ(), .ACK_PULSE(), .ACK_ID());

	//////////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic cmp_irq(input logic got, input logic exp);
		cmp({31'h0, got}, {31'h0, exp});
	endtask : cmp_irq

	// A real acknowledge pulses; a spurious one only updates the id
	task automatic cmp_ack(input logic p, input logic [9:0] id,
		input logic [9:0] e);
		cmp({21'h0, p, id}, {21'h0, e != ipa_pkg::SPURIOUS_ID, e});
	endtask : cmp_ack

	task automatic end_sim;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= !sel_x;
		wr_x <= sel_x;
		@(posedge clk);
		wr <= 1'b0;
		wr_x <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk);
		exp_q.push_back(e);
		addr <= a;
		rd <= !sel_x;
		rd_x <= sel_x;
		@(posedge clk);
		rd <= 1'b0;
		rd_x <= 1'b0;
	endtask : rd_reg

	task automatic pend(input int i);
		@(posedge clk);
		raise <= 16'h1 << i;
		@(posedge clk);
		raise <= 16'h0;
	endtask : pend

	// Signal lags pending by the model and the output register
	task automatic irq(input logic e);
		repeat (3) @(posedge clk);
		@(negedge clk);
		cmp_irq(irq_req, e);
	endtask : irq

	function automatic logic [11:0] pa(input int i);
		return ipa_pkg::OFS_PRIO_BASE + 12'(4 * i);
	endfunction : pa

	// Read data stand only in the cycle after the strobe
	// The copy not read shows zero, so the union is the answer
	always @(posedge clk) begin
		rd_d  <= rd || rd_x;
		ack_d <= rd && addr == ipa_pkg::OFS_ACK;
	end
	always @(negedge clk) begin
		if (rd_d) begin
			rd_exp = exp_q.pop_front();
			cmp(rdata | rdata_x, rd_exp);
			if (ack_d) begin
				cmp_ack(ack_pulse, ack_id, rd_exp[9:0]);
			end
		end
	end

	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		end_sim();
	end

	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		rd_reg(ipa_pkg::OFS_MASK, 32'h0);
		// Width probe with signaling off and nothing pending
		for (int i = 0; i < 4; i++) begin
			wr_reg(pa(i), 32'hff);
			rd_reg(pa(i), 32'hf0);
			v = $random(seed);
			wr_reg(pa(i), {24'h0, v[7:0]});
			rd_reg(pa(i), {24'h0, v[7:4], 4'h0});
		end
		wr_reg(ipa_pkg::OFS_CONTROL, 32'h1);
		wr_reg(pa(2), 32'h30);
		pend(2);
		irq(1'b0);
		wr_reg(ipa_pkg::OFS_MASK, 32'hff);
		rd_reg(ipa_pkg::OFS_MASK, 32'hf0);
		wr_reg(pa(2), 32'hf0);
		irq(1'b0);
		wr_reg(ipa_pkg::OFS_BP, 32'h4);
		wr_reg(pa(2), 32'h30);
		wr_reg(ipa_pkg::OFS_MASK, 32'h30);
		irq(1'b0);
		wr_reg(ipa_pkg::OFS_MASK, 32'h40);
		irq(1'b1);
		rd_reg(ipa_pkg::OFS_ACK, 32'h2);
		rd_reg(ipa_pkg::OFS_RUNNING, 32'h20);
		wr_reg(pa(3), 32'h20);
		pend(3);
		irq(1'b0);
		wr_reg(pa(1), 32'h10);
		pend(1);
		irq(1'b1);
		rd_reg(ipa_pkg::OFS_RUNNING, 32'h20);
		rd_reg(ipa_pkg::OFS_ACK, 32'h1);
		rd_reg(ipa_pkg::OFS_RUNNING, 32'h0);
		wr_reg(ipa_pkg::OFS_DROP, 32'h1);
		rd_reg(ipa_pkg::OFS_RUNNING, 32'h20);
		wr_reg(ipa_pkg::OFS_DEACT, 32'h1);
		wr_reg(ipa_pkg::OFS_DEACT, 32'h2);
		rd_reg(ipa_pkg::OFS_RUNNING, 32'hff);
		wr_reg(pa(0), 32'h30);
		pend(0);
		rd_reg(ipa_pkg::OFS_ACK, 32'h3);
		rd_reg(ipa_pkg::OFS_ACK, 32'h3ff);
		wr_reg(ipa_pkg::OFS_DEACT, 32'h3);
		wr_reg(ipa_pkg::OFS_BP, 32'h7);
		rd_reg(ipa_pkg::OFS_ACK, 32'h0);
		rd_reg(ipa_pkg::OFS_RUNNING, 32'h0);
		wr_reg(ipa_pkg::OFS_DEACT, 32'h0);
		wr_reg(ipa_pkg::OFS_GROUP, 32'h2);
		pend(1);
		rd_reg(ipa_pkg::OFS_ACK, 32'h1);
		rd_reg(ipa_pkg::OFS_RUNNING, 32'h10);
		wr_reg(ipa_pkg::OFS_DEACT, 32'h1);
		wr_reg(ipa_pkg::OFS_CONTROL, 32'h3);
		pend(1);
		rd_reg(ipa_pkg::OFS_ACK, 32'h1);
		rd_reg(ipa_pkg::OFS_RUNNING, 32'h0);
		sel_x = 1'b1;
		rd_reg(pa(0), 32'h50);
		wr_reg(pa(0), 32'hff);
		rd_reg(pa(0), 32'h50);
		wr_reg(ipa_pkg::OFS_BP, 32'h0);
		rd_reg(ipa_pkg::OFS_BP, 32'h2);
		wr_reg(ipa_pkg::OFS_ABP, 32'h5);
		rd_reg(ipa_pkg::OFS_ABP, 32'h2);
		wr_reg(ipa_pkg::OFS_CONTROL, 32'h3);
		rd_reg(ipa_pkg::OFS_CONTROL, 32'h1);
		wr_reg(pa(1), 32'hff);
		rd_reg(pa(1), 32'hf0);
		repeat (3) @(posedge clk);
		end_sim();
	end
endmodule : interrupt_priority_arbiter_tb

// file: tb/ipa_arbiter_assertions.sv
// Port checker of the interrupt priority arbiter.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps

module ipa_arbiter_chk #(
	parameter int N_IRQ     = 16,
	parameter int IMPL_BITS = 4
) (
	input wire logic             CLK,
	input wire logic             RESET,
	input wire logic [11:0]      ADDR,
	input wire logic             RD,
	input wire logic [31:0]      RDATA,
	input wire logic [N_IRQ-1:0] PENDING,
	input wire logic             IRQ_REQ,
	input wire logic             ACK_PULSE,
	input wire logic [9:0]       ACK_ID
);
	localparam logic [7:0] LOW = 8'hff >> IMPL_BITS;
	logic [N_IRQ-1:0] pend_q;

	always_ff @(posedge CLK) begin
		pend_q <= PENDING;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	AST_LOW_BITS: assert property (
		$past(RD && (ADDR == ipa_pkg::OFS_MASK || ADDR[10]))
		|-> (RDATA[7:0] & LOW) == 8'h00)
		else $error("unimplemented priority bits read nonzero");
	AST_ACK_SLOT: assert property (
		ACK_PULSE |-> $past(RD && ADDR == ipa_pkg::OFS_ACK))
		else $error("acknowledge pulse without acknowledge read");
	AST_ACK_PEND: assert property (ACK_PULSE |-> pend_q[ACK_ID])
		else $error("acknowledged interrupt was not pending");
	AST_SPUR: assert property (
		$past(RD && ADDR == ipa_pkg::OFS_ACK) && !ACK_PULSE
		|-> ACK_ID == ipa_pkg::SPURIOUS_ID)
		else $error("empty acknowledge gave no spurious id");
	AST_ID_HOLD: assert property (
		!$past(RD && ADDR == ipa_pkg::OFS_ACK) |-> $stable(ACK_ID))
		else $error("acknowledge id changed without a read");
	AST_IRQ_PEND: assert property (IRQ_REQ |-> $past(PENDING) != '0)
		else $error("interrupt signaled with nothing pending");
	AST_RUN_GRP: assert property (
		$past(RD && ADDR == ipa_pkg::OFS_RUNNING)
		|-> RDATA[7:0] == 8'hff || !RDATA[0])
		else $error("running priority not group masked");
	AST_ACK_RANGE: assert property (ACK_PULSE |-> ACK_ID < N_IRQ)
		else $error("real acknowledge with out of range id");
	AST_ACK_DATA: assert property (ACK_PULSE |-> RDATA[9:0] == ACK_ID)
		else $error("acknowledge data differs from id");
endmodule : ipa_arbiter_chk

//////////////////////////////////////////////////////////////////////////////
bind ipa_arbiter ipa_arbiter_chk #(.N_IRQ(N_IRQ), .IMPL_BITS(IMPL_BITS))
	ipa_arbiter_chk_i (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .RD(RD),
	.RDATA(RDATA), .PENDING(PENDING), .IRQ_REQ(IRQ_REQ),
	.ACK_PULSE(ACK_PULSE), .ACK_ID(ACK_ID));

// file: tb/ipa_src_model.sv
// Interrupt sources seen by the arbiter: one pending level each.
// Assumes the core clears a source only by acknowledging it.
`timescale 1ns/100ps

module ipa_src_model #(
	parameter int N_IRQ = 16
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [N_IRQ-1:0] raise,
	input  wire logic             ack_pulse,
	input  wire logic [9:0]       ack_id,
	output logic      [N_IRQ-1:0] pending
);
	// Acknowledge wins over a raise of the same line in one cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			pending <= '0;
		end else begin
			pending <= (pending | raise)
				& ~(ack_pulse ? N_IRQ'(1) << ack_id : '0);
		end
	end
endmodule : ipa_src_model
